// ---- design/csi_params.svh ----
// Constants for the combustion shutdown interlock
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH
`define CSI_CLK_MHZ 200
`define CSI_DEBOUNCE_US 10
`define CSI_DEBOUNCE_CYC (`CSI_DEBOUNCE_US * `CSI_CLK_MHZ)
`define CSI_CNT_W 12
`define CSI_HI_MIN 16'shffc4
`define CSI_HI_MAX 16'sh044c
`define CSI_LO_MIN 16'sh0000
`define CSI_LO_MAX 16'sh01f4
`define CSI_ST_W 4
`define CSI_ST_LEVEL 0
`define CSI_ST_SHUT 1
`define CSI_ST_TEMP 2
`define CSI_ST_FAULT 3
`define CSI_ADDR_STATUS 4'h0
`define CSI_ADDR_MASK 4'h1
`define CSI_ADDR_INPUTS 4'h2
`define CSI_ADDR_LATCH 4'h3
`define CSI_MASK_RST 4'h0
`endif

// ---- design/csi_pkg.sv ----
// Types for the combustion shutdown interlock
package csi_pkg;
	typedef enum logic [2:0] {CSI_DISP_RUN, CSI_DISP_OFF, CSI_DISP_RR, CSI_DISP_LLSD,
		CSI_DISP_SD, CSI_DISP_POC, CSI_DISP_LATCH, CSI_DISP_TEMP} csi_disp_e;
	typedef struct packed {
		logic main_sw;
		logic remote_sw;
		logic level_sd;
		logic shut_sd;
		logic closure_proof_input;
	} csi_sw_s;
	typedef struct packed {
		logic flame_fail;
		logic modbus_stop;
		logic tc_one_fault;
		logic tc_two_fault;
		logic sol_short;
		logic power_fail_latch;
	} csi_flt_s;
	typedef struct packed {
		logic ign_power;
		logic pilot_valve;
		logic main_valve;
		logic temperature_main_valve;
	} csi_out_s;
endpackage : csi_pkg

// ---- design/csi_top.sv ----
// Combustion shutdown interlock and latch logic
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "csi_params.svh"

////////////////////////////////////////////////////////////////////////////////
module csi_debounce (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic raw,
	output logic clean
);
	import csi_pkg::*;
	typedef struct packed {
		logic s1;
		logic s2;
		logic [`CSI_CNT_W-1:0] cnt;
		logic clean;
	} csi_db_s;
	csi_db_s st_r;
	csi_db_s st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1;
		if (st_r.s2 == st_r.clean)
			st_nxt.cnt = '0;
		else if (st_r.cnt == `CSI_CNT_W'(`CSI_DEBOUNCE_CYC - 1))
		begin
			st_nxt.clean = st_r.s2;
			st_nxt.cnt = '0;
		end
		else
			st_nxt.cnt = st_r.cnt + `CSI_CNT_W'(1);
	end
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign clean = st_r.clean;
	property p_db_hold;
		@(posedge clock) disable iff (!arst_n)
			st_r.cnt != `CSI_CNT_W'(`CSI_DEBOUNCE_CYC - 1) |=> $stable(clean);
	endproperty
	a_db_hold: assert property (p_db_hold)
		else $error("debounced level moved before settle time");
endmodule : csi_debounce

////////////////////////////////////////////////////////////////////////////////
module csi_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire csi_pkg::csi_sw_s sw_raw,
	input wire logic latch_sel,
	input wire logic tc_one_low_range,
	input wire logic tc_two_low_range,
	input wire logic signed [15:0] thermocouple_one,
	input wire logic signed [15:0] thermocouple_two,
	input wire csi_pkg::csi_flt_s faults,
	input wire logic ign_valve_req,
	input wire logic main_valve_req,
	input wire logic temperature_main_valve_valve_req,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output csi_pkg::csi_out_s outs,
	output csi_pkg::csi_disp_e disp,
	output logic [3:0] latch_cause,
	output logic alarm,
	output logic alarm_contact,
	output logic irq
);
	import csi_pkg::*;
	typedef struct packed {
		logic running;
		logic [3:0] latched;
		logic main_q;
		logic remote_q;
		logic [`CSI_ST_W-1:0] status;
		logic [`CSI_ST_W-1:0] mask;
		logic [31:0] rdata;
		csi_out_s outs;
		csi_disp_e disp;
		logic alarm;
		logic alarm_contact;
		logic irq;
	} csi_st_s;
	csi_st_s st_r;
	csi_st_s st_nxt;
	csi_sw_s sw;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_db
			csi_debounce u_db (
				.clock(clock),
				.arst_n(arst_n),
				.raw(sw_raw[gi]),
				.clean(sw[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Range checks, switch decode, latch clear, permit and events
	logic tc1_ok;
	logic tc2_ok;
	logic temp_ok;
	logic onoff_ok;
	logic sd_ok;
	logic clear_latch;
	logic permit;
	logic [`CSI_ST_W-1:0] events;
	always_comb
	begin
		tc1_ok = tc_one_low_range ?
			(thermocouple_one >= `CSI_LO_MIN && thermocouple_one <= `CSI_LO_MAX) :
			(thermocouple_one >= `CSI_HI_MIN && thermocouple_one <= `CSI_HI_MAX);
		tc2_ok = tc_two_low_range ?
			(thermocouple_two >= `CSI_LO_MIN && thermocouple_two <= `CSI_LO_MAX) :
			(thermocouple_two >= `CSI_HI_MIN && thermocouple_two <= `CSI_HI_MAX);
		temp_ok = tc1_ok && tc2_ok && !faults.tc_one_fault && !faults.tc_two_fault;
		onoff_ok = sw.main_sw && sw.remote_sw;
		sd_ok = sw.level_sd && sw.shut_sd;
		// Falling edge of either on/off switch resets latches
		clear_latch = (st_r.main_q && !sw.main_sw) || (st_r.remote_q && !sw.remote_sw);
		// closure proof only gates a start
		permit = onoff_ok && sd_ok && temp_ok && (st_r.latched == 4'h0) && !faults.modbus_stop
			&& (st_r.running || sw.closure_proof_input);
		events = '0;
		events[`CSI_ST_LEVEL] = !sw.level_sd;
		events[`CSI_ST_SHUT] = !sw.shut_sd;
		events[`CSI_ST_TEMP] = !temp_ok;
		events[`CSI_ST_FAULT] = faults.flame_fail || faults.sol_short;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.main_q = sw.main_sw;
		st_nxt.remote_q = sw.remote_sw;
		if (clear_latch)
			st_nxt.latched = 4'h0;
		else if (latch_sel)
		begin
			// a trip is recorded even if the input recloses
			if (!sw.level_sd)
				st_nxt.latched[`CSI_ST_LEVEL] = 1'b1;
			if (!sw.shut_sd)
				st_nxt.latched[`CSI_ST_SHUT] = 1'b1;
		end
		st_nxt.running = permit;
		st_nxt.outs.ign_power = permit;
		st_nxt.outs.pilot_valve = permit && ign_valve_req;
		st_nxt.outs.main_valve = permit && main_valve_req;
		st_nxt.outs.temperature_main_valve = permit && temperature_main_valve_valve_req;
		if (!sw.main_sw)
			st_nxt.disp = CSI_DISP_OFF;
		else if (!sw.remote_sw)
			st_nxt.disp = CSI_DISP_RR;
		else if (!sw.level_sd)
			st_nxt.disp = CSI_DISP_LLSD;
		else if (!sw.shut_sd)
			st_nxt.disp = CSI_DISP_SD;
		else if (st_r.latched != 4'h0)
			st_nxt.disp = CSI_DISP_LATCH;
		else if (!sw.closure_proof_input && !st_r.running)
			st_nxt.disp = CSI_DISP_POC;
		else if (!temp_ok)
			st_nxt.disp = CSI_DISP_TEMP;
		else
			st_nxt.disp = CSI_DISP_RUN;
		st_nxt.alarm = !permit || !sw.closure_proof_input || (|events)
			|| (st_r.latched != 4'h0) || faults.power_fail_latch || faults.modbus_stop;
		st_nxt.alarm_contact = !st_nxt.alarm;
		// Set wins over write-one-clear
		st_nxt.status = st_r.status | events;
		if (wr && addr == `CSI_ADDR_STATUS)
			st_nxt.status = (st_r.status & ~wdata[`CSI_ST_W-1:0]) | events;
		if (wr && addr == `CSI_ADDR_MASK)
			st_nxt.mask = wdata[`CSI_ST_W-1:0];
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
		st_nxt.rdata = '0;
		if (rd)
		begin
			unique case (addr)
				`CSI_ADDR_STATUS: st_nxt.rdata = {28'h0, st_r.status};
				`CSI_ADDR_MASK: st_nxt.rdata = {28'h0, st_r.mask};
				`CSI_ADDR_INPUTS: st_nxt.rdata = {26'h0, st_r.running, sw};
				`CSI_ADDR_LATCH: st_nxt.rdata = {28'h0, st_r.latched};
				default: st_nxt.rdata = '0;
			endcase
		end
	end
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r <= '0;
			st_r.alarm <= 1'b1;
			st_r.disp <= CSI_DISP_OFF;
		end
		else
			st_r <= st_nxt;
	end
	assign rdata = st_r.rdata;
	assign outs = st_r.outs;
	assign disp = st_r.disp;
	assign latch_cause = st_r.latched;
	assign alarm = st_r.alarm;
	assign alarm_contact = st_r.alarm_contact;
	assign irq = st_r.irq;

	////////////////////////////////////////////////////////////////////////////////
	sequence s_level_open;
		!sw.level_sd;
	endsequence
	property p_power_needs_permit;
		@(posedge clock) disable iff (!arst_n) outs.ign_power |-> $past(permit);
	endproperty
	a_power_needs_permit: assert property (p_power_needs_permit)
		else $error("ignition power without permit");
	property p_level_kills;
		@(posedge clock) disable iff (!arst_n) s_level_open |=> !outs.ign_power && !outs.pilot_valve;
	endproperty
	a_level_kills: assert property (p_level_kills)
		else $error("level open did not drop outputs");
	property p_shut_kills;
		@(posedge clock) disable iff (!arst_n) !sw.shut_sd |=> !outs.ign_power && !outs.main_valve;
	endproperty
	a_shut_kills: assert property (p_shut_kills)
		else $error("shutdown open did not drop outputs");
	property p_latch_holds;
		@(posedge clock) disable iff (!arst_n)
			latch_sel && !sw.level_sd && !clear_latch |=> latch_cause[`CSI_ST_LEVEL];
	endproperty
	a_latch_holds: assert property (p_latch_holds)
		else $error("level trip not latched");
	property p_main_clear;
		@(posedge clock) disable iff (!arst_n) clear_latch |=> latch_cause == 4'h0;
	endproperty
	a_main_clear: assert property (p_main_clear)
		else $error("latch not cleared by switch");
	property p_disp_off;
		@(posedge clock) disable iff (!arst_n) !sw.main_sw |=> disp == CSI_DISP_OFF;
	endproperty
	a_disp_off: assert property (p_disp_off)
		else $error("OFF not shown");
	property p_disp_rr;
		@(posedge clock) disable iff (!arst_n) sw.main_sw && !sw.remote_sw |=> disp == CSI_DISP_RR;
	endproperty
	a_disp_rr: assert property (p_disp_rr)
		else $error("rr not shown");
	property p_contact;
		@(posedge clock) disable iff (!arst_n) alarm_contact |-> !alarm && outs.ign_power;
	endproperty
	a_contact: assert property (p_contact)
		else $error("alarm contact closed in alarm");
	property p_stop_alarm;
		@(posedge clock) disable iff (!arst_n) faults.modbus_stop |=> alarm;
	endproperty
	a_stop_alarm: assert property (p_stop_alarm)
		else $error("stop command without alarm");

	////////////////////////////////////////////////////////////////////////////////
	sequence s_ready;
		onoff_ok && sd_ok && temp_ok && st_r.latched == 4'h0 && !faults.modbus_stop;
	endsequence
	property p_remote_clear;
		@(posedge clock) disable iff (!arst_n)
			st_r.remote_q && !sw.remote_sw |=> latch_cause == 4'h0;
	endproperty
	a_remote_clear: assert property (p_remote_clear)
		else $error("latch not cleared by remote switch");
	property p_disp_llsd;
		@(posedge clock) disable iff (!arst_n)
			sw.main_sw && sw.remote_sw && !sw.level_sd |=> disp == CSI_DISP_LLSD;
	endproperty
	a_disp_llsd: assert property (p_disp_llsd)
		else $error("LLSd not shown");
	property p_disp_sd;
		@(posedge clock) disable iff (!arst_n)
			sw.main_sw && sw.remote_sw && sw.level_sd && !sw.shut_sd |=> disp == CSI_DISP_SD;
	endproperty
	a_disp_sd: assert property (p_disp_sd)
		else $error("Sd not shown");
	property p_restart;
		@(posedge clock) disable iff (!arst_n)
			!latch_sel ##0 s_ready ##0 sw.closure_proof_input |=> outs.ign_power;
	endproperty
	a_restart: assert property (p_restart)
		else $error("no restart after shutdowns closed");
	property p_latch_shut;
		@(posedge clock) disable iff (!arst_n)
			latch_sel && !sw.shut_sd && !clear_latch |=> latch_cause[`CSI_ST_SHUT];
	endproperty
	a_latch_shut: assert property (p_latch_shut)
		else $error("shutdown trip not latched");
	property p_latch_blocks;
		@(posedge clock) disable iff (!arst_n)
			st_r.latched != 4'h0 |=> !outs.ign_power;
	endproperty
	a_latch_blocks: assert property (p_latch_blocks)
		else $error("power with a latch recorded");
	property p_temp_kills;
		@(posedge clock) disable iff (!arst_n)
			!temp_ok |=> !outs.ign_power;
	endproperty
	a_temp_kills: assert property (p_temp_kills)
		else $error("power with temperature out of range");
	property p_poc_start;
		@(posedge clock) disable iff (!arst_n)
			!st_r.running && !sw.closure_proof_input |=> !outs.ign_power;
	endproperty
	a_poc_start: assert property (p_poc_start)
		else $error("start with closure proof open");
	property p_poc_ignored;
		@(posedge clock) disable iff (!arst_n)
			st_r.running ##0 s_ready |=> outs.ign_power;
	endproperty
	a_poc_ignored: assert property (p_poc_ignored)
		else $error("running system stopped by closure proof");
	property p_onoff_kills;
		@(posedge clock) disable iff (!arst_n)
			!onoff_ok |=> outs == '0;
	endproperty
	a_onoff_kills: assert property (p_onoff_kills)
		else $error("on/off open did not drop outputs");
	property p_alarm_events;
		@(posedge clock) disable iff (!arst_n)
			(|events) || faults.power_fail_latch |=> alarm;
	endproperty
	a_alarm_events: assert property (p_alarm_events)
		else $error("event without alarm");
	property p_contact_open;
		@(posedge clock) disable iff (!arst_n)
			alarm |-> !alarm_contact;
	endproperty
	a_contact_open: assert property (p_contact_open)
		else $error("alarm contact closed while alarm");
	property p_pilot_follow;
		@(posedge clock) disable iff (!arst_n)
			permit && ign_valve_req |=> outs.pilot_valve;
	endproperty
	a_pilot_follow: assert property (p_pilot_follow)
		else $error("pilot valve not energised");
	property p_main_follow;
		@(posedge clock) disable iff (!arst_n)
			permit && main_valve_req |=> outs.main_valve;
	endproperty
	a_main_follow: assert property (p_main_follow)
		else $error("main valve not energised");
	property p_temperature_main_valve_follow;
		@(posedge clock) disable iff (!arst_n)
			permit && temperature_main_valve_valve_req |=> outs.temperature_main_valve;
	endproperty
	a_temperature_main_valve_follow: assert property (p_temperature_main_valve_follow)
		else $error("temperature main valve not energised");
endmodule : csi_top

// ---- verif/csi_field.sv ----
// Field dry contacts that chatter after each change
`timescale 1ns/10ps
module csi_field (
	input wire logic clock,
	input wire csi_pkg::csi_sw_s want,
	output csi_pkg::csi_sw_s sw_raw
);
	import csi_pkg::*;
	csi_sw_s last = 5'h1f;
	csi_sw_s flip = 5'h00;
	int cnt = 0;
	int seed = 32'h5542;
	initial sw_raw = 5'h1f;
	always @(posedge clock)
	begin
		if (want !== last)
		begin
			cnt <= 24;
			flip <= want ^ last;
		end
		else if (cnt != 0)
			cnt <= cnt - 1;
		// Changed contacts bounce for a while
		sw_raw <= (cnt != 0) ? want ^ (flip & 5'($random(seed))) : want;
		last <= want;
	end
endmodule : csi_field

// ---- verif/csi_top_tb_top.sv ----
// Testbench for the combustion shutdown interlock
`timescale 1ns/10ps
`include "csi_params.svh"
module csi_top_tb_top;
	import csi_pkg::*;
	logic clock = 0, arst_n = 0, latch_sel = 0, lo1 = 0, wr = 0, rd = 0, rd_d = 0, snap = 0;
	logic lo2 = 1;
	logic signed [15:0] t1 = 16'sh0064, t2 = 16'sh0000;
	logic [3:0] addr = 4'h0, latch_cause;
	logic [31:0] wdata = 32'h0, rdata;
	logic [31:0] qe[$], qm[$];
	csi_sw_s want = 5'h1f, sw_raw;
	csi_flt_s faults = 6'h00;
	csi_out_s outs;
	csi_disp_e disp;
	logic alarm, alarm_contact, irq;
	int errors = 0, num_checks = 0, seed = 32'h5542;
	localparam logic [13:0] run_v = 14'h3c02, m_all = 14'h3ffe, m_lc = 14'h3f86;
	initial forever #2.5 clock = ~clock;
	csi_field i_csi_field (.clock, .want, .sw_raw);
	csi_top i_csi_top (.clock, .arst_n, .sw_raw, .latch_sel, .tc_one_low_range(lo1),
		.tc_two_low_range(lo2), .thermocouple_one(t1), .thermocouple_two(t2), .faults,
		.ign_valve_req(1'b1), .main_valve_req(1'b1), .temperature_main_valve_valve_req(1'b1), .addr, .wdata,
		.wr, .rd, .rdata, .outs, .disp, .latch_cause, .alarm, .alarm_contact, .irq);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [13:0] off(input csi_disp_e d, input logic [3:0] lc);
		return {4'h0, d, lc, 3'b100};
	endfunction : off
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
		cmp("rdata", e, g);
	endtask : cmp_rd
	task automatic cmp_out(input logic [31:0] e, input logic [31:0] g);
		cmp("outputs", e, g);
	endtask : cmp_out
	task automatic results();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	task automatic sw(input logic [4:0] v);
		@(posedge clock);
		want <= v;
		repeat (2100) @(posedge clock);
	endtask : sw
	task automatic ex(input logic [13:0] e, input logic [13:0] m);
		repeat (2) @(posedge clock);
		qe.push_back({18'h0, e});
		qm.push_back({18'h0, m});
		snap <= 1'b1;
		@(posedge clock);
		snap <= 1'b0;
		@(posedge clock);
	endtask : ex
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		if (!w)
		begin
			qe.push_back(d);
			qm.push_back(32'hffffffff);
		end
		@(posedge clock);
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic tc(input logic lo, input logic signed [15:0] v, input logic [13:0] e);
		@(posedge clock);
		lo1 <= lo;
		t1 <= v;
		t2 <= 16'($unsigned($random(seed)) % 500);
		ex(e, m_all);
	endtask : tc
	////////////////////////////////////////////////////////////////////////////////
	// Monitor takes the oldest note per result
	always @(posedge clock)
	begin
		rd_d <= rd;
		if (rd_d)
			cmp_rd(qe.pop_front(), rdata & qm.pop_front());
		else if (snap)
			cmp_out(qe.pop_front(), {18'h0, outs, disp, latch_cause, alarm, alarm_contact, irq} & qm.pop_front());
	end
	initial
	begin
		#250000;
		errors++;
		results();
	end
	initial
	begin
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		bus(1'b1, `CSI_ADDR_MASK, 32'h1);
		sw(5'h1f);
		ex(run_v, m_all);
		bus(1'b0, `CSI_ADDR_INPUTS, 32'h3f);
		bus(1'b0, 4'hf, 32'h0);
		bus(1'b1, `CSI_ADDR_STATUS, 32'hf);
		bus(1'b0, `CSI_ADDR_MASK, 32'h1);
		$display("test 1 done");
		sw(5'h1b);
		ex(off(CSI_DISP_LLSD, 4'h0) | 14'h1, 14'h3fff);
		sw(5'h1f);
		ex(run_v, m_all);
		bus(1'b0, `CSI_ADDR_STATUS, 32'h1);
		bus(1'b1, `CSI_ADDR_STATUS, 32'h1);
		ex(run_v, 14'h3fff);
		$display("test 2 done");
		latch_sel <= 1'b1;
		sw(5'h1d);
		ex(off(CSI_DISP_SD, 4'h0), m_lc);
		sw(5'h1f);
		ex(off(CSI_DISP_LATCH, 4'h2), m_all);
		sw(5'h17);
		ex(off(CSI_DISP_RR, 4'h0), m_lc);
		sw(5'h1f);
		ex(run_v, m_all);
		sw(5'h1b);
		sw(5'h1f);
		ex(off(CSI_DISP_LATCH, 4'h1), m_all);
		sw(5'h0f);
		ex(off(CSI_DISP_OFF, 4'h0), m_lc);
		sw(5'h1f);
		ex(run_v, m_all);
		$display("test 3 done");
		sw(5'h1e);
		ex(14'h3c00, 14'h3c00);
		sw(5'h0e);
		sw(5'h1e);
		ex(off(CSI_DISP_POC, 4'h0), m_all);
		sw(5'h1f);
		tc(1'b1, 16'sh01f5, off(CSI_DISP_TEMP, 4'h0));
		tc(1'b1, 16'sh01f4, run_v);
		tc(1'b0, 16'sh01f5, run_v);
		tc(1'b0, 16'shffc3, off(CSI_DISP_TEMP, 4'h0));
		tc(1'b0, 16'sh044d, off(CSI_DISP_TEMP, 4'h0));
		tc(1'b0, 16'sh044c, run_v);
		lo2 <= 1'b0;
		t2 <= 16'shffc4;
		ex(run_v, m_all);
		t2 <= 16'shffc3;
		ex(off(CSI_DISP_TEMP, 4'h0), m_all);
		lo2 <= 1'b1;
		t2 <= 16'sh0000;
		$display("test 4 done");
		for (int i = 0; i < 6; i++)
		begin
			faults <= 6'h1 << i;
			ex(14'h4, 14'h6);
		end
		$display("test 5 done");
		results();
	end
endmodule : csi_top_tb_top
